// [pml_map.svh]
`ifndef PML_MAP_SVH
`define PML_MAP_SVH
// Register offset (host word index 0xa, byte offset 0x14 within the bank)
`define PML_CTRL_OFFSET   4'ha
`define PML_CTRL_RESET    16'h0000
// Field positions
`define PML_SPEED_BIT     13
`define PML_DUPLEX_BIT    12
`define PML_AUTONEG_SELECT_BIT      11
`define PML_FIRST_LED_OUT_LSB      5
`define PML_SECOND_LED_OUT_LSB      2
// Writable bit mask; reserved bits read as zero
`define PML_WR_MASK       16'h38fc
// LED select encodings
`define PML_LED_LINK_ANY  3'h0
`define PML_LED_RSVD      3'h1
`define PML_LED_LINK10    3'h2
`define PML_LED_FDX       3'h3
`define PML_LED_TXRX      3'h4
`define PML_LED_LINK100   3'h5
`define PML_LED_RX        3'h6
`define PML_LED_TX        3'h7
`endif

// [pml_pkg.sv]
package pml_pkg;
   // Status indications from the PHY and MAC, active high
   typedef struct packed {
      logic link100;
      logic link10;
      logic full_dpx;
      logic rx_act;
      logic tx_act;
   } pml_led_src_t;
   // PHY control register 0 view and negotiation result
   typedef struct packed {
      logic phy_speed;
      logic phy_duplex;
      logic phy_autoneg_enable;
      logic neg_speed;
      logic neg_duplex;
   } pml_phy_in_t;
   // Effective PHY operating mode
   typedef struct packed {
      logic autoneg_on;
      logic speed100;
      logic full_duplex;
   } pml_phy_mode_t;
endpackage

// [pml_phy_mode_led.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pml_map.svh"
module pml_phy_mode_led #(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   // Host register port
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic [1:0]            reg_be,
   input  wire logic [15:0]           reg_wdata,
   output logic      [15:0]           reg_rdata,
   // PHY side
   input  wire pml_pkg::pml_phy_in_t  phy_in,
   output pml_pkg::pml_phy_mode_t     phy_mode,
   // MAC duplex switch from transmit control
   input  wire logic                  mac_full_duplex_switch,
   output logic                       mac_full_duplex,
   // LED sources and pins
   input  wire pml_pkg::pml_led_src_t led_src,
   output logic                       first_led_out,
   output logic                       second_led_out
);
   // Refuse an address port too narrow to reach the control word
   if (ADDR_W < 4) begin : g_addr_w_check
      $error("ADDR_W must be at least 4");
   end

   // LED select decode, shared by both pins
   function automatic logic led_pick(input logic [2:0] sel,
                                     input pml_pkg::pml_led_src_t s);
      logic r;
      r = 1'b0;
      case (sel)
         `PML_LED_LINK_ANY: r = s.link100 | s.link10;
         `PML_LED_RSVD:     r = 1'b0;
         `PML_LED_LINK10:   r = s.link10;
         `PML_LED_FDX:      r = s.full_dpx;
         `PML_LED_TXRX:     r = s.tx_act | s.rx_act;
         `PML_LED_LINK100:  r = s.link100;
         `PML_LED_RX:       r = s.rx_act;
         `PML_LED_TX:       r = s.tx_act;
         default:           r = 1'b0;
      endcase
      return r;
   endfunction

   logic [15:0]            ctrl_q;
   logic [15:0]            ctrl_d;
   logic                   hit;
   logic [15:0]            be_mask;
   logic                   autoneg_select_sel;
   logic [2:0]             first_led_out_sel;
   logic [2:0]             second_led_out_sel;
   pml_pkg::pml_phy_mode_t mode_d;
   pml_pkg::pml_phy_mode_t mode_q;
   logic                   first_led_out_d;
   logic                   first_led_out_q;
   logic                   second_led_out_d;
   logic                   second_led_out_q;
   logic                   fdx_q;
   logic [15:0]            rdata_d;

   // Register write with byte lanes; reserved bits stay zero
   always_comb begin
      hit     = (reg_addr == ADDR_W'(`PML_CTRL_OFFSET));
      be_mask = {{8{reg_be[1]}}, {8{reg_be[0]}}};
      ctrl_d  = ctrl_q;
      if (reg_wr && hit) begin
         ctrl_d = ((ctrl_q & ~be_mask) | (reg_wdata & be_mask))
                  & `PML_WR_MASK;
      end
      rdata_d = hit ? ctrl_q : 16'h0000;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `PML_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign autoneg_select_sel = ctrl_q[`PML_AUTONEG_SELECT_BIT];
   assign first_led_out_sel = ctrl_q[`PML_FIRST_LED_OUT_LSB +: 3];
   assign second_led_out_sel = ctrl_q[`PML_SECOND_LED_OUT_LSB +: 3];

   // Effective mode and LED routing
   always_comb begin
      mode_d.autoneg_on = autoneg_select_sel & phy_in.phy_autoneg_enable;
      if (!autoneg_select_sel) begin
         mode_d.speed100    = ctrl_q[`PML_SPEED_BIT];
         mode_d.full_duplex = ctrl_q[`PML_DUPLEX_BIT];
      end else if (phy_in.phy_autoneg_enable) begin
         mode_d.speed100    = phy_in.neg_speed;
         mode_d.full_duplex = phy_in.neg_duplex;
      end else begin
         mode_d.speed100    = phy_in.phy_speed;
         mode_d.full_duplex = phy_in.phy_duplex;
      end
      first_led_out_d = led_pick(first_led_out_sel, led_src);
      second_led_out_d = led_pick(second_led_out_sel, led_src);
   end

   // Output registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_q    <= '0;
         first_led_out_q    <= 1'b0;
         second_led_out_q    <= 1'b0;
         fdx_q     <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         mode_q    <= mode_d;
         first_led_out_q    <= first_led_out_d;
         second_led_out_q    <= second_led_out_d;
         fdx_q     <= mac_full_duplex_switch;
         reg_rdata <= rdata_d;
      end
   end

   assign phy_mode        = mode_q;
   assign first_led_out   = first_led_out_q;
   assign second_led_out  = second_led_out_q;
   assign mac_full_duplex = fdx_q;

   // Assertions
   property p_manual_speed;
      @(posedge clock) disable iff (!nrst)
      !autoneg_select_sel |=> phy_mode.speed100 == $past(ctrl_q[`PML_SPEED_BIT]);
   endproperty
   a_manual_speed: assert property (p_manual_speed)
      else $error("manual speed mismatch");

   property p_manual_override;
      @(posedge clock) disable iff (!nrst)
      (!autoneg_select_sel && phy_in.phy_speed != ctrl_q[`PML_SPEED_BIT])
      |=> phy_mode.speed100 != $past(phy_in.phy_speed);
   endproperty
   a_manual_override: assert property (p_manual_override)
      else $error("register speed did not override PHY");

   property p_autoneg_select_speed;
      @(posedge clock) disable iff (!nrst)
      autoneg_select_sel |=> phy_mode.speed100 == ($past(phy_in.phy_autoneg_enable)
         ? $past(phy_in.neg_speed) : $past(phy_in.phy_speed));
   endproperty
   a_autoneg_select_speed: assert property (p_autoneg_select_speed)
      else $error("negotiated speed source wrong");

   property p_manual_dpx;
      @(posedge clock) disable iff (!nrst)
      !autoneg_select_sel |=> phy_mode.full_duplex == $past(ctrl_q[`PML_DUPLEX_BIT]);
   endproperty
   a_manual_dpx: assert property (p_manual_dpx)
      else $error("manual duplex mismatch");

   property p_dpx_override;
      @(posedge clock) disable iff (!nrst)
      (!autoneg_select_sel && phy_in.phy_duplex != ctrl_q[`PML_DUPLEX_BIT])
      |=> phy_mode.full_duplex != $past(phy_in.phy_duplex);
   endproperty
   a_dpx_override: assert property (p_dpx_override)
      else $error("register duplex did not override PHY");

   property p_autoneg_select_dpx;
      @(posedge clock) disable iff (!nrst)
      autoneg_select_sel |=> phy_mode.full_duplex == ($past(phy_in.phy_autoneg_enable)
         ? $past(phy_in.neg_duplex) : $past(phy_in.phy_duplex));
   endproperty
   a_autoneg_select_dpx: assert property (p_autoneg_select_dpx)
      else $error("negotiated duplex source wrong");

   property p_autoneg_select_on;
      @(posedge clock) disable iff (!nrst)
      ##1 phy_mode.autoneg_on == $past(autoneg_select_sel & phy_in.phy_autoneg_enable);
   endproperty
   a_autoneg_select_on: assert property (p_autoneg_select_on)
      else $error("autoneg mode wrong");

   property p_first_led_out_link;
      @(posedge clock) disable iff (!nrst)
      (first_led_out_sel == `PML_LED_LINK_ANY) |=>
         first_led_out == $past(led_src.link100 | led_src.link10);
   endproperty
   a_first_led_out_link: assert property (p_first_led_out_link)
      else $error("first LED link wrong");

   property p_second_led_out_tx;
      @(posedge clock) disable iff (!nrst)
      (second_led_out_sel == `PML_LED_TX) |=> second_led_out == $past(led_src.tx_act);
   endproperty
   a_second_led_out_tx: assert property (p_second_led_out_tx)
      else $error("second LED tx wrong");

   property p_first_led_out_rsvd;
      @(posedge clock) disable iff (!nrst)
      (first_led_out_sel == `PML_LED_RSVD) |=> !first_led_out;
   endproperty
   a_first_led_out_rsvd: assert property (p_first_led_out_rsvd)
      else $error("reserved LED code not dark");

   property p_second_led_out_rx;
      @(posedge clock) disable iff (!nrst)
      (second_led_out_sel == `PML_LED_RX) |=> second_led_out == $past(led_src.rx_act);
   endproperty
   a_second_led_out_rx: assert property (p_second_led_out_rx)
      else $error("second LED rx wrong");

   property p_mac_dpx;
      @(posedge clock) disable iff (!nrst)
      ##1 mac_full_duplex == $past(mac_full_duplex_switch);
   endproperty
   a_mac_dpx: assert property (p_mac_dpx)
      else $error("MAC duplex not following switch");

endmodule // pml_phy_mode_led
`default_nettype wire

// [pml_phy_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pml_phy_model (
   // Clock and chosen conditions
   input  wire logic             clock,
   input  wire logic [4:0]       phy_cfg,
   input  wire logic [4:0]       src_cfg,
   input  wire logic             tgt_fdx,
   // Device side levels
   output var pml_pkg::pml_phy_in_t  phy_in,
   output var pml_pkg::pml_led_src_t led_src,
   output var logic              mac_sw
);
   // Levels move only at the falling edge; reset covers the first one
   always @(negedge clock) begin
      phy_in <= phy_cfg;
      led_src <= src_cfg;
      mac_sw <= tgt_fdx;
   end
endmodule // pml_phy_model
`default_nettype wire

// [test_pml_phy_mode_led.sv]
`timescale 1ns/100ps
`default_nettype none
module test_pml_phy_mode_led;
   logic                  clock = 1'b0;
   logic                  nrst = 1'b0;
   logic [3:0]            reg_addr = 4'h0;
   logic                  reg_wr = 1'b0;
   logic [1:0]            reg_be = 2'h0;
   logic [15:0]           reg_wdata = 16'h0000;
   logic [15:0]           reg_rdata;
   logic [4:0]            phy_cfg = 5'h00;
   logic [4:0]            src_cfg = 5'h00;
   logic                  tgt_fdx = 1'b0;
   pml_pkg::pml_phy_in_t  phy_in;
   pml_pkg::pml_led_src_t led_src;
   pml_pkg::pml_phy_mode_t phy_mode;
   logic                  mac_sw;
   logic                  mac_fdx;
   logic                  led_a;
   logic                  led_b;
   logic                  on;
   logic                  sp;
   logic                  dx;
   logic                  ea;
   logic                  eb;
   logic [15:0]           exp_m;
   int                    failures = 0;
   int                    checked = 0;
   // Clock, 10 ns period
   always #5 clock = ~clock;
   pml_phy_mode_led #(.ADDR_W(4)) dut_u (.clock(clock), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_be(reg_be),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .phy_in(phy_in),
      .phy_mode(phy_mode), .mac_full_duplex_switch(mac_sw),
      .mac_full_duplex(mac_fdx), .led_src(led_src),
      .first_led_out(led_a), .second_led_out(led_b));
   pml_phy_model model_u (.clock(clock), .phy_cfg(phy_cfg),
      .src_cfg(src_cfg), .tgt_fdx(tgt_fdx), .phy_in(phy_in),
      .led_src(led_src), .mac_sw(mac_sw));
   // Comparisons
   task automatic cmp(input string w, input logic [15:0] e,
                      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic cmpb(input string w, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %b seen %b", w, e, g);
      end
   endtask
   // Host accesses, one write pulse per wr call
   task automatic wr(input logic [3:0] a, input logic [1:0] be,
                     input logic [15:0] d);
      @(negedge clock);
      {reg_addr, reg_be, reg_wdata, reg_wr} = {a, be, d, 1'b1};
      @(negedge clock);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e,
                     input string w);
      @(negedge clock);
      reg_addr = a;
      @(negedge clock);
      cmp(w, e, reg_rdata);
   endtask
   task automatic settle;
      repeat (3) @(negedge clock);
   endtask
   // Expected LED level, s = link100 link10 fdx rx tx
   function automatic logic led_exp(input logic [2:0] c,
                                    input logic [4:0] s);
      logic [7:0] v;
      v = {s[0], s[1], s[4], s[1] | s[0], s[2], s[3], 1'b0, s[4] | s[3]};
      return v[c];
   endfunction
   task automatic finish_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000;
      failures++;
      finish_test();
   end
   // Test sequence
   initial begin
      repeat (10) @(negedge clock);
      nrst = 1'b1;
      src_cfg = 5'b01000;
      settle();
      rd(4'ha, 16'h0000, "ctrl reset");
      cmpb("led a reset", 1'b1, led_a);
      cmpb("led b reset", 1'b1, led_b);
      $display("test reset done");
      wr(4'h3, 2'h3, 16'h3800);
      rd(4'h3, 16'h0000, "unmapped");
      rd(4'ha, 16'h0000, "ctrl after unmapped");
      wr(4'ha, 2'h1, 16'hffff);
      rd(4'ha, 16'h00fc, "low lane");
      wr(4'ha, 2'h2, 16'hffff);
      rd(4'ha, 16'h38fc, "high lane");
      $display("test lanes done");
      for (int i = 0; i < 64; i++) begin
         on = i[0] & i[3];
         sp = i[0] ? (i[3] ? i[5] : i[4]) : i[1];
         dx = i[0] ? (i[3] ? ~i[5] : ~i[4]) : i[2];
         exp_m = {2'h0, i[1], i[2], i[0], 11'h000};
         phy_cfg = {i[4], ~i[4], i[3], i[5], ~i[5]};
         tgt_fdx = dx;
         wr(4'ha, 2'h3, exp_m);
         rd(4'ha, exp_m, "ctrl mode");
         settle();
         cmpb("autoneg", on, phy_mode.autoneg_on);
         cmpb("speed", sp, phy_mode.speed100);
         cmpb("duplex", dx, phy_mode.full_duplex);
         if (i[0]) begin
            cmpb("neg duplex", dx, phy_mode.full_duplex);
         end
         cmpb("mac duplex", dx, mac_fdx);
      end
      $display("test modes done");
      for (int c = 0; c < 8; c++) begin
         wr(4'ha, 2'h3, {8'h00, c[2:0], ~c[2:0], 2'h0});
         for (int s = 0; s < 32; s++) begin
            src_cfg = s[4:0];
            settle();
            ea = led_exp(c[2:0], s[4:0]);
            eb = led_exp(~c[2:0], s[4:0]);
            cmpb("led a", ea, led_a);
            cmpb("led b", eb, led_b);
         end
      end
      $display("test leds done");
      // Mid-run reset clears the register and every output
      nrst = 1'b0;
      src_cfg = 5'b10000;
      repeat (2) @(negedge clock);
      cmp("rdata in reset", 16'h0000, reg_rdata);
      cmp("mode in reset", 16'h0000, 16'(phy_mode));
      cmpb("led a in reset", 1'b0, led_a);
      cmpb("led b in reset", 1'b0, led_b);
      nrst = 1'b1;
      settle();
      rd(4'ha, 16'h0000, "ctrl after reset");
      cmpb("led a after reset", 1'b1, led_a);
      cmpb("led b after reset", 1'b1, led_b);
      $display("test mid reset done");
      finish_test();
   end
endmodule // test_pml_phy_mode_led
`default_nettype wire
